// ### hw/fifo_top.sv
// Dual-clock 18-bit FIFO core with programmable flags and chaining
//
// What this block does
// - 18-bit write bus in, 18-bit read bus out
// - Write edge, enable low, not full: push
// - Read edge, enable low, not empty: pop oldest
// - Load low: writes go to offset registers
// - Load low: reads return offset registers
// - Empty flag low when empty, read edges or retransmit only
// - Full flag low when full, write edges only
// - Almost-empty low at or below offset
// - Almost-empty on read edges unless strap high
// - Almost-full low within offset of full
// - Almost-full on write edges unless strap high
// - Shared pin: half-full, or chain out cascaded
// - First-load strap low marks first chain device
// - Standalone: first-load pin strobes retransmit
// - Chain inputs from previous device, else low
// - Reset empties buffer, empty flag low
// - Two 12-bit offsets from low input bits
// - Load accesses alternate empty then full offset
// - Reads when empty keep last output word
`timescale 1ns/100ps
module fifo_top #(parameter int DEPTH = fifo_pkg::DEPTH_DEF)
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic WRITE_CLK,
  input wire logic READ_CLK,
  input wire logic [17:0] WRITE_DATA_IN,
  input wire logic WRITE_EN_N,
  input wire logic READ_EN_N,
  input wire logic LOAD_SELECT_N,
  input wire logic RESET_N,
  input wire logic FLAG_SYNC_STRAP,
  input wire logic FIRST_LOADER_OR_RETRANSMIT,
  input wire logic WRITE_CHAIN_IN,
  input wire logic READ_CHAIN_IN,
  input wire logic CASCADE_EN,
  output logic [17:0] READ_DATA_OUT,
  output logic EMPTY_FLAG_N,
  output logic FULL_FLAG_N,
  output logic ALMOST_EMPTY_FLAG_N,
  output logic ALMOST_FULL_FLAG_N,
  output logic WRITE_CHAIN_OUT_OR_HALF_FULL,
  output logic READ_CHAIN_OUT
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;

  logic [fifo_pkg::PIN_W-1:0] pins;
  logic [fifo_pkg::PIN_W-1:0] sy;
  logic [fifo_pkg::PIN_W-1:0] pv;
  logic wr_tick, rd_tick, wr_tick_d_ff, rd_tick_d_ff;
  logic wen_n, ren_n, ld_n, soft_rst, strap, casc, rt_pulse;
  logic wxi_rise, rxi_rise;
  logic [17:0] din;
  logic wr_ok, rd_ok, ld_wr, ld_rd;
  logic [PW-1:0] wr_ptr_ff, rd_ptr_ff;
  logic [11:0] ae_off_ff, af_off_ff;
  logic wsel_ff, rsel_ff, wtok_ff, rtok_ff, wxo_ff, rxo_ff;
  logic [17:0] mem [DEPTH];

  flag_if #(.PW(PW)) lv ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture; both link clocks are sampled and their edges found here
  assign pins = {WRITE_DATA_IN, CASCADE_EN, READ_CHAIN_IN, WRITE_CHAIN_IN,
    FIRST_LOADER_OR_RETRANSMIT, FLAG_SYNC_STRAP, RESET_N, LOAD_SELECT_N,
    READ_EN_N, WRITE_EN_N, READ_CLK, WRITE_CLK};

  pin_sync #(.W(fifo_pkg::PIN_W)) u_sync (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .din(pins),
    .sync(sy),
    .prev(pv)
  );

  // Controls and data come from the older sample, taken before the edge,
  // so a hold time shorter than our period cannot corrupt them
  assign wr_tick = sy[fifo_pkg::P_WCLK] & ~pv[fifo_pkg::P_WCLK];
  assign rd_tick = sy[fifo_pkg::P_RCLK] & ~pv[fifo_pkg::P_RCLK];
  assign wen_n = pv[fifo_pkg::P_WEN];
  assign ren_n = pv[fifo_pkg::P_REN];
  assign ld_n = pv[fifo_pkg::P_LD];
  assign din = pv[fifo_pkg::P_DATA +: 18];
  assign soft_rst = ~sy[fifo_pkg::P_RST];
  assign strap = sy[fifo_pkg::P_FLAG_SYNC_STRAP];
  assign casc = sy[fifo_pkg::P_CASC];
  assign rt_pulse = ~casc & sy[fifo_pkg::P_FLRT]
    & ~pv[fifo_pkg::P_FLRT];
  assign wxi_rise = sy[fifo_pkg::P_WXI] & ~pv[fifo_pkg::P_WXI];
  assign rxi_rise = sy[fifo_pkg::P_RXI] & ~pv[fifo_pkg::P_RXI];

  // Request decode; load select steers both sides to the offsets
  assign wr_ok = wr_tick & ~wen_n & ld_n & FULL_FLAG_N & wtok_ff;
  assign rd_ok = rd_tick & ~ren_n & ld_n & EMPTY_FLAG_N & rtok_ff;
  assign ld_wr = wr_tick & ~wen_n & ~ld_n;
  assign ld_rd = rd_tick & ~ren_n & ~ld_n;

  ////////////////////////////////////////////////////////////////////////////
  // Level logic sees both pointers on the one sampling clock, so no
  // pointer is ever read mid-change
  assign lv.wr_ptr = wr_ptr_ff;
  assign lv.rd_ptr = rd_ptr_ff;
  assign lv.ae_off = ae_off_ff;
  assign lv.af_off = af_off_ff;

  level_calc #(.DEPTH(DEPTH), .PW(PW)) u_level (
    .lv(lv)
  );

  // Flags refresh one cycle after the edge, once the pointers moved
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_tick_d_ff <= 1'b0;
      rd_tick_d_ff <= 1'b0;
    end
    else
    begin
      wr_tick_d_ff <= wr_tick;
      rd_tick_d_ff <= rd_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage; plain flip-flops without reset, pointers define validity
  always_ff @(posedge REF_CLK)
  begin
    if (wr_ok)
      mem[wr_ptr_ff[AW-1:0]] <= din;
  end

  // Write pointer
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      wr_ptr_ff <= '0;
    else if (soft_rst)
      wr_ptr_ff <= '0;
    else if (wr_ok)
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
  end

  // Read pointer; retransmit rewinds to the first word since reset,
  // which only replays correctly before the write side has wrapped
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rd_ptr_ff <= '0;
    else if (soft_rst || rt_pulse)
      rd_ptr_ff <= '0;
    else if (rd_ok)
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset registers and their alternating selectors
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ae_off_ff <= fifo_pkg::AE_OFF_RST;
      af_off_ff <= fifo_pkg::AF_OFF_RST;
      wsel_ff <= 1'b0;
    end
    else if (soft_rst)
    begin
      ae_off_ff <= fifo_pkg::AE_OFF_RST;
      af_off_ff <= fifo_pkg::AF_OFF_RST;
      wsel_ff <= 1'b0;
    end
    else if (ld_wr)
    begin
      if (!wsel_ff)
        ae_off_ff <= din[11:0];
      else
        af_off_ff <= din[11:0];
      wsel_ff <= ~wsel_ff;
    end
  end

  // Read-side selector walks the same order independently
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rsel_ff <= 1'b0;
    else if (soft_rst)
      rsel_ff <= 1'b0;
    else if (ld_rd)
      rsel_ff <= ~rsel_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output register; holds its word when no read is taken
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      READ_DATA_OUT <= fifo_pkg::DOUT_RST;
    else if (soft_rst)
      READ_DATA_OUT <= fifo_pkg::DOUT_RST;
    else if (ld_rd)
      READ_DATA_OUT <= {6'h00, rsel_ff ? af_off_ff : ae_off_ff};
    else if (rd_ok)
      READ_DATA_OUT <= mem[rd_ptr_ff[AW-1:0]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary flags, each owned by its own side
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      EMPTY_FLAG_N <= 1'b0;
    else if (soft_rst)
      EMPTY_FLAG_N <= 1'b0;
    else if (rd_tick_d_ff || rt_pulse)
      EMPTY_FLAG_N <= lv.not_empty;
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      FULL_FLAG_N <= 1'b1;
    else if (soft_rst)
      FULL_FLAG_N <= 1'b1;
    else if (wr_tick_d_ff)
      FULL_FLAG_N <= lv.not_full;
  end

  // Strap high lets the almost flags follow the level every cycle
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ALMOST_EMPTY_FLAG_N <= 1'b0;
      ALMOST_FULL_FLAG_N <= 1'b1;
    end
    else if (soft_rst)
    begin
      ALMOST_EMPTY_FLAG_N <= 1'b0;
      ALMOST_FULL_FLAG_N <= 1'b1;
    end
    else
    begin
      if (strap || rd_tick_d_ff)
        ALMOST_EMPTY_FLAG_N <= lv.ae_n;
      if (strap || wr_tick_d_ff)
        ALMOST_FULL_FLAG_N <= lv.af_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chain tokens: only the holder accepts writes or reads; the first
  // loader starts with both, every device does when not cascaded
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wtok_ff <= 1'b0;
      wxo_ff <= 1'b0;
    end
    else if (soft_rst)
    begin
      wtok_ff <= ~casc | ~sy[fifo_pkg::P_FLRT];
      wxo_ff <= 1'b0;
    end
    else if (wr_ok && casc && lv.used_last_w)
    begin
      wtok_ff <= 1'b0;
      wxo_ff <= 1'b1;
    end
    else
    begin
      if (wxi_rise && casc)
        wtok_ff <= 1'b1;
      if (wr_tick)
        wxo_ff <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rtok_ff <= 1'b0;
      rxo_ff <= 1'b0;
    end
    else if (soft_rst)
    begin
      rtok_ff <= ~casc | ~sy[fifo_pkg::P_FLRT];
      rxo_ff <= 1'b0;
    end
    else if (rd_ok && casc && lv.used_last_r)
    begin
      rtok_ff <= 1'b0;
      rxo_ff <= 1'b1;
    end
    else
    begin
      if (rxi_rise && casc)
        rtok_ff <= 1'b1;
      if (rd_tick)
        rxo_ff <= 1'b0;
    end
  end

  // Shared pin: pulse when cascaded, half-full level otherwise
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      WRITE_CHAIN_OUT_OR_HALF_FULL <= 1'b1;
      READ_CHAIN_OUT <= 1'b0;
    end
    else
    begin
      WRITE_CHAIN_OUT_OR_HALF_FULL <= casc ? wxo_ff : lv.half_n;
      READ_CHAIN_OUT <= rxo_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_push;
    wr_ok ##1 1'b1;
  endsequence

  a_push_advances: assert property (s_push |->
    wr_ptr_ff == $past(wr_ptr_ff) + 1'b1 || $past(soft_rst))
    else $error("write pointer did not advance on push");
  a_full_blocks: assert property (
    wr_tick && !FULL_FLAG_N && !soft_rst |=> $stable(wr_ptr_ff))
    else $error("write taken while full");
  a_empty_holds: assert property (
    rd_tick && !EMPTY_FLAG_N && ld_n && !soft_rst |=>
    $stable(READ_DATA_OUT))
    else $error("output changed on read while empty");
  a_load_no_push: assert property (
    ld_wr && !soft_rst |=> $stable(wr_ptr_ff) && wsel_ff != $past(wsel_ff))
    else $error("load write pushed or did not alternate");
  a_empty_rd_only: assert property (
    $changed(EMPTY_FLAG_N) |-> $past(rd_tick_d_ff) || $past(soft_rst)
    || $past(rt_pulse))
    else $error("empty flag moved off the read side");
  a_full_wr_only: assert property (
    $changed(FULL_FLAG_N) |-> $past(wr_tick_d_ff) || $past(soft_rst))
    else $error("full flag moved off the write side");
  a_ae_sync_mode: assert property (
    !strap && $changed(ALMOST_EMPTY_FLAG_N) |->
    $past(rd_tick_d_ff) || $past(soft_rst))
    else $error("almost-empty moved off the read side");
  a_af_sync_mode: assert property (
    !strap && $changed(ALMOST_FULL_FLAG_N) |->
    $past(wr_tick_d_ff) || $past(soft_rst))
    else $error("almost-full moved off the write side");
  a_reset_empty: assert property (
    soft_rst |=> !EMPTY_FLAG_N && wr_ptr_ff == rd_ptr_ff)
    else $error("reset did not empty the buffer");
  a_pop_data: assert property (
    rd_ok && !soft_rst |=> READ_DATA_OUT == $past(mem[rd_ptr_ff[AW-1:0]]))
    else $error("popped word is not the oldest");
endmodule : fifo_top

// ### inc/fifo_pkg.sv
// Shared constants for the 18-bit dual-clock FIFO
package fifo_pkg;
  localparam int DATA_W = 18;
  localparam int OFF_W = 12;
  localparam int DEPTH_DEF = 256;
  localparam logic [11:0] AE_OFF_RST = 12'h007;
  localparam logic [11:0] AF_OFF_RST = 12'h007;
  localparam logic [17:0] DOUT_RST = 18'h00000;
  // Bit positions inside the synchronised pin vector
  localparam int P_WCLK = 0;
  localparam int P_RCLK = 1;
  localparam int P_WEN = 2;
  localparam int P_REN = 3;
  localparam int P_LD = 4;
  localparam int P_RST = 5;
  localparam int P_FLAG_SYNC_STRAP = 6;
  localparam int P_FLRT = 7;
  localparam int P_WXI = 8;
  localparam int P_RXI = 9;
  localparam int P_CASC = 10;
  localparam int P_DATA = 11;
  localparam int PIN_W = 29;
endpackage : fifo_pkg

// ### inc/flag_if.sv
// Pointer view and level results shared by the core and the level logic
`timescale 1ns/100ps
interface flag_if #(parameter int PW = 9) ();
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [11:0] ae_off;
  logic [11:0] af_off;
  logic not_empty;
  logic not_full;
  logic ae_n;
  logic af_n;
  logic half_n;
  logic used_last_w;
  logic used_last_r;
  modport calc (input wr_ptr, input rd_ptr, input ae_off, input af_off,
    output not_empty, output not_full, output ae_n, output af_n,
    output half_n, output used_last_w, output used_last_r);
  modport core (output wr_ptr, output rd_ptr, output ae_off,
    output af_off, input not_empty, input not_full, input ae_n,
    input af_n, input half_n, input used_last_w, input used_last_r);
endinterface : flag_if

// ### hw/pin_sync.sv
// Two-stage synchroniser for pins plus one extra stage for edge finding
`timescale 1ns/100ps
module pin_sync #(parameter int W = 1)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] sync,
  output logic [W-1:0] prev
);
  logic [W-1:0] meta_ff;

  ////////////////////////////////////////////////////////////////////////////
  // One chain per bit; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_ff[i] <= 1'b0;
          sync[i] <= 1'b0;
          prev[i] <= 1'b0;
        end
        else
        begin
          meta_ff[i] <= din[i];
          sync[i] <= meta_ff[i];
          prev[i] <= sync[i];
        end
      end
    end
  endgenerate
endmodule : pin_sync

// ### hw/level_calc.sv
// Fill level compares for empty, full, almost and half-full points
`timescale 1ns/100ps
module level_calc #(parameter int DEPTH = 256, parameter int PW = 9)
(
  flag_if.calc lv
);
  logic [PW-1:0] diff;
  logic [13:0] used;

  // Pointers carry one wrap bit, so the difference is the word count;
  // it is taken at pointer width first so a wrapped pair stays right
  assign diff = lv.wr_ptr - lv.rd_ptr;
  assign used = 14'(diff);
  assign lv.not_empty = (used != 14'h0000);
  assign lv.not_full = (used != 14'(DEPTH));
  // Limits follow DEPTH, so every depth option gets its own points
  assign lv.ae_n = !(used <= 14'(lv.ae_off));
  assign lv.af_n = !((used + 14'(lv.af_off)) >= 14'(DEPTH));
  assign lv.half_n = !(used > 14'(DEPTH / 2));
  // Chain hand-over points: this push fills, this pop empties
  assign lv.used_last_w = (used == 14'(DEPTH - 1));
  assign lv.used_last_r = (used == 14'h0001);
endmodule : level_calc

// ### dv/stream_partner.sv
// Writer and reader partner that drives the link pins of the FIFO
`timescale 1ns/100ps
module stream_partner
(
  input wire logic clk,
  output logic wclk,
  output logic rclk,
  output logic [17:0] din,
  output logic wen_n,
  output logic ren_n,
  output logic ld_n
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle pins: link clocks stand still low, load deselected
  initial
  begin
    wclk = 1'b0;
    rclk = 1'b0;
    din = 18'h15555;
    wen_n = 1'b1;
    ren_n = 1'b1;
    ld_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One 170 ns link period; controls settle 4 cycles before the rise
  task automatic frame(input logic rd, input logic en_n, input logic ld,
    input logic [17:0] d);
    @(posedge clk);
    ld_n <= ld;
    if (rd)
      ren_n <= en_n;
    else
    begin
      wen_n <= en_n;
      din <= d;
    end
    repeat (4) @(posedge clk);
    rclk <= rd;
    wclk <= !rd;
    repeat (8) @(posedge clk);
    rclk <= 1'b0;
    wclk <= 1'b0;
    repeat (4) @(posedge clk);
    // Released bus shows the inverse so a stale word never looks valid
    ren_n <= 1'b1;
    wen_n <= 1'b1;
    ld_n <= 1'b1;
    din <= ~din;
  endtask : frame
endmodule : stream_partner

// ### dv/testbench.sv
// Self-checking bench for the dual-clock 18-bit FIFO
`timescale 1ns/100ps
module testbench;
  localparam int DEPTH = 256;
  localparam int LIMIT = 20000;
  typedef struct packed {logic [1:0] op; logic ld; logic [17:0] d;
    logic [17:0] q; logic [3:0] fl;} row_type;
  // Ops: 0 write, 1 read, 2 read edge with enable off; fl = EF AE FF AF
  row_type rows [16] = '{
    '{2'd0, 1'b0, 18'h00003, 18'h0, 4'h3},
    '{2'd0, 1'b0, 18'h00005, 18'h0, 4'h3},
    '{2'd1, 1'b0, 18'h0, 18'h00003, 4'h3},
    '{2'd1, 1'b0, 18'h0, 18'h00005, 4'h3},
    '{2'd0, 1'b1, 18'h3ffff, 18'h0, 4'h3},
    '{2'd0, 1'b1, 18'h00001, 18'h0, 4'h3},
    '{2'd0, 1'b1, 18'h2a5a5, 18'h0, 4'h3},
    '{2'd0, 1'b1, 18'h15a5a, 18'h0, 4'h3},
    '{2'd0, 1'b1, 18'h20000, 18'h0, 4'h3},
    '{2'd2, 1'b1, 18'h0, 18'h0, 4'hf},
    '{2'd1, 1'b1, 18'h0, 18'h3ffff, 4'hf},
    '{2'd1, 1'b1, 18'h0, 18'h00001, 4'hb},
    '{2'd1, 1'b1, 18'h0, 18'h2a5a5, 4'hb},
    '{2'd1, 1'b1, 18'h0, 18'h15a5a, 4'hb},
    '{2'd1, 1'b1, 18'h0, 18'h20000, 4'h3},
    '{2'd1, 1'b1, 18'h0, 18'h20000, 4'h3}};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_n = 1'b1;
  logic strap = 1'b0;
  logic flrt = 1'b0;
  logic casc = 1'b0;
  logic write_chain_in = 1'b0;
  logic read_chain_in = 1'b0;
  logic wclk, rclk, wen_n, ren_n, ld_n, ef_n, ff_n, ae_n, af_n, hf, rco;
  logic [17:0] din, q;
  logic [2:0] exp3;
  int n, fails = 0, checks = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and partner; chain pins start low, standalone
  always #5 ref_clk = ~ref_clk;
  fifo_top #(.DEPTH(DEPTH)) fifo_top_i (.REF_CLK(ref_clk),
    .SYS_RST(sys_rst), .WRITE_CLK(wclk), .READ_CLK(rclk),
    .WRITE_DATA_IN(din), .WRITE_EN_N(wen_n), .READ_EN_N(ren_n),
    .LOAD_SELECT_N(ld_n), .RESET_N(reset_n), .FLAG_SYNC_STRAP(strap),
    .FIRST_LOADER_OR_RETRANSMIT(flrt), .WRITE_CHAIN_IN(write_chain_in),
    .READ_CHAIN_IN(read_chain_in), .CASCADE_EN(casc), .READ_DATA_OUT(q),
    .EMPTY_FLAG_N(ef_n), .FULL_FLAG_N(ff_n), .ALMOST_EMPTY_FLAG_N(ae_n),
    .ALMOST_FULL_FLAG_N(af_n), .WRITE_CHAIN_OUT_OR_HALF_FULL(hf),
    .READ_CHAIN_OUT(rco));
  stream_partner stream_partner_i (.clk(ref_clk), .wclk(wclk),
    .rclk(rclk), .din(din), .wen_n(wen_n), .ren_n(ren_n), .ld_n(ld_n));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count; unknowns never match
  task automatic check(input logic [17:0] got, input logic [17:0] exp,
    input string what);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // Counts and verdict, the only exit
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // Device reset pin held long enough for the synchroniser to see it
  task automatic pin_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : pin_reset
  // Hang guard sized well past the longest sequence
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check(18'({ef_n, ae_n, ff_n, af_n, hf}), 18'h07, "reset");
    check(q, 18'h0, "reset data");
    $display("reset test done");
    for (int i = 0; i < 16; i++)
    begin
      stream_partner_i.frame(rows[i].op != 2'd0, rows[i].op == 2'd2,
        rows[i].ld, rows[i].d);
      if (rows[i].op == 2'd1)
        check(q, rows[i].q, "row data");
      check(18'({ef_n, ae_n, ff_n, af_n}), 18'(rows[i].fl), "row");
    end
    $display("row test done");
    // One write past full must be refused
    for (int i = 0; i <= DEPTH; i++)
    begin
      stream_partner_i.frame(1'b0, 1'b0, 1'b1, 18'(i));
      n = (i < DEPTH) ? i + 1 : DEPTH;
      exp3 = {n < DEPTH, n + 5 < DEPTH, n <= DEPTH / 2};
      check(18'({ff_n, af_n, hf}), 18'(exp3), "fill");
    end
    stream_partner_i.frame(1'b1, 1'b1, 1'b1, 18'h0);
    stream_partner_i.frame(1'b1, 1'b0, 1'b1, 18'h0);
    check(q, 18'h0, "first out");
    check(18'(ff_n), 18'h0, "full kept until write edge");
    stream_partner_i.frame(1'b0, 1'b1, 1'b1, 18'h0);
    check(18'(ff_n), 18'h1, "full cleared");
    for (int i = 1; i < DEPTH; i++)
    begin
      stream_partner_i.frame(1'b1, 1'b0, 1'b1, 18'h0);
      check(q, 18'(i), "drain");
    end
    check(18'(ef_n), 18'h0, "drained");
    $display("full test done");
    // Strap high: almost-empty follows writes with no read edge
    strap <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      stream_partner_i.frame(1'b0, 1'b0, 1'b1, 18'(i));
      check(18'({ef_n, ae_n}), 18'(i > 2), "strap");
    end
    $display("strap test done");
    pin_reset();
    check(18'({ef_n, ae_n, ff_n, af_n, hf}), 18'h07, "pin reset");
    for (int i = 1; i < 4; i++)
      stream_partner_i.frame(1'b0, 1'b0, 1'b1, 18'(i));
    stream_partner_i.frame(1'b1, 1'b1, 1'b1, 18'h0);
    for (int i = 1; i < 3; i++)
    begin
      stream_partner_i.frame(1'b1, 1'b0, 1'b1, 18'h0);
      check(q, 18'(i), "before replay");
    end
    flrt <= 1'b1;
    repeat (4) @(posedge ref_clk);
    flrt <= 1'b0;
    repeat (8) @(posedge ref_clk);
    stream_partner_i.frame(1'b1, 1'b0, 1'b1, 18'h0);
    check(q, 18'h1, "replay");
    $display("retransmit test done");
    // Cascade, first loader: the last word read passes the read token on
    casc <= 1'b1;
    pin_reset();
    check(18'(hf), 18'h0, "chain out idle");
    stream_partner_i.frame(1'b0, 1'b0, 1'b1, 18'h00011);
    stream_partner_i.frame(1'b1, 1'b1, 1'b1, 18'h0);
    stream_partner_i.frame(1'b1, 1'b0, 1'b1, 18'h0);
    check(q, 18'h00011, "chain read");
    check(18'(rco), 18'h1, "read chain out");
    stream_partner_i.frame(1'b0, 1'b0, 1'b1, 18'h00022);
    stream_partner_i.frame(1'b1, 1'b1, 1'b1, 18'h0);
    check(18'(rco), 18'h0, "read chain out ends");
    stream_partner_i.frame(1'b1, 1'b0, 1'b1, 18'h0);
    check(q, 18'h00011, "read without token");
    read_chain_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    read_chain_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    stream_partner_i.frame(1'b1, 1'b0, 1'b1, 18'h0);
    check(q, 18'h00022, "read with token");
    // Not the first loader: writes wait for the write token
    flrt <= 1'b1;
    pin_reset();
    stream_partner_i.frame(1'b0, 1'b0, 1'b1, 18'h00033);
    stream_partner_i.frame(1'b1, 1'b1, 1'b1, 18'h0);
    check(18'(ef_n), 18'h0, "write without token");
    write_chain_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    write_chain_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    stream_partner_i.frame(1'b0, 1'b0, 1'b1, 18'h00033);
    stream_partner_i.frame(1'b1, 1'b1, 1'b1, 18'h0);
    check(18'(ef_n), 18'h1, "write with token");
    $display("cascade test done");
    results();
  end
endmodule : testbench
